// file: verilog/psdt_map.vh
// Constants of the sequence delay timer: timing figures, counts and field layouts.
`ifndef PSDT_MAP_VH
`define PSDT_MAP_VH
`define PSDT_CLK_HZ 25000000
`define PSDT_T_100MS_MS 100
`define PSDT_T_500MS_MS 500
`define PSDT_T_1S_MS 1000
`define PSDT_T_5S_MS 5000
`define PSDT_T_POR_MS 50
`define PSDT_T_NVW_MS 5
`define PSDT_T_GLITCH_NS 50
`define PSDT_CYC_PER_MS (`PSDT_CLK_HZ / 1000)
`define PSDT_CYC_100MS (`PSDT_T_100MS_MS * `PSDT_CYC_PER_MS)
`define PSDT_CYC_500MS (`PSDT_T_500MS_MS * `PSDT_CYC_PER_MS)
`define PSDT_CYC_1S (`PSDT_T_1S_MS * `PSDT_CYC_PER_MS)
`define PSDT_CYC_5S (`PSDT_T_5S_MS * `PSDT_CYC_PER_MS)
`define PSDT_CYC_POR (`PSDT_T_POR_MS * `PSDT_CYC_PER_MS)
`define PSDT_CYC_NVW (`PSDT_T_NVW_MS * `PSDT_CYC_PER_MS)
`define PSDT_CYC_GLITCH ((`PSDT_T_GLITCH_NS * (`PSDT_CLK_HZ / 1000000) + 999) / 1000)
`define PSDT_SEL_DEFAULT 2'h0
`define PSDT_CFG_DEFAULT 8'h00
`define PSDT_CFG_RST_LSB 0
`define PSDT_CFG_CH0_LSB 2
`define PSDT_CFG_CH1_LSB 4
`define PSDT_CFG_CH2_LSB 6
`define PSDT_ADDR_CFG 4'h0
`define PSDT_ADDR_STATUS 4'h4
`define PSDT_ADDR_NVSTAGE 4'h8
`endif

// file: verilog/psdt_glitch.v
// Synchroniser and pulse filter for one serial bus input.
`timescale 1ns/1ps
`default_nettype none
module psdt_glitch #(
  parameter integer FILT_CYC = 2
) (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  input wire pin_in,
  output reg pin_out
);
  // --------------------------------------------------------------
  // Three-stage synchroniser, change seen when stages two and three agree.
  // --------------------------------------------------------------
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg [3:0] cnt_r;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      cnt_r <= 4'h0;
      pin_out <= 1'b1;
    end else if (clk_en) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A new level must persist FILT_CYC + 1 cycles before it is passed on.
      if (s2_r != s3_r || s3_r == pin_out) begin
        cnt_r <= 4'h0;
      end else if (cnt_r >= FILT_CYC[3:0] - 4'h1) begin
        pin_out <= s3_r; // [R5]
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // psdt_glitch
`default_nettype wire

// file: verilog/psdt_top.v
// Programmable sequence delay timer with Avalon-MM configuration port.
// Behaviour
// [R1] Reset release delay chosen by two-bit field.
// [R2] Each channel has own selectable sequencing delay.
// [R3] Stop after write starts timed nonvolatile write.
// [R4] Host waits write time or polls busy.
// [R5] Serial inputs ignore pulses under 50 ns.
// [R6] Reset delay starts once all goods active.
// [R7] Fixed power-on delay before any good output.
// [R8] Reset held until sequencing done, then delayed.
// [R9] Select fields loaded from nonvolatile store first.
`timescale 1ns/1ps
`default_nettype none
`include "psdt_map.vh"
module psdt_top #(
  parameter integer CYC_100MS = `PSDT_CYC_100MS,
  parameter integer CYC_500MS = `PSDT_CYC_500MS,
  parameter integer CYC_1S = `PSDT_CYC_1S,
  parameter integer CYC_5S = `PSDT_CYC_5S,
  parameter integer CYC_POR = `PSDT_CYC_POR,
  parameter integer CYC_NVW = `PSDT_CYC_NVW
) (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [2:0] supply_ok,
  output reg [2:0] supply_good_delayed_output,
  output reg reset_out_n,
  input wire scl_in,
  input wire sda_in,
  output reg scl_filt,
  output reg sda_filt,
  output reg nv_busy
);
  // --------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------
  function [27:0] sel_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: sel_cycles = CYC_100MS[27:0];
        2'h1: sel_cycles = CYC_500MS[27:0];
        2'h2: sel_cycles = CYC_1S[27:0];
        default: sel_cycles = CYC_5S[27:0];
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // Bus input filters
  // --------------------------------------------------------------
  wire scl_f;
  wire sda_f;
  psdt_glitch #(.FILT_CYC(`PSDT_CYC_GLITCH)) u_scl (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .pin_in(scl_in), .pin_out(scl_f));
  psdt_glitch #(.FILT_CYC(`PSDT_CYC_GLITCH)) u_sda (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .pin_in(sda_in), .pin_out(sda_f));

  // --------------------------------------------------------------
  // Supply status synchroniser
  // --------------------------------------------------------------
  reg [2:0] ok1_r;
  reg [2:0] ok2_r;
  reg [2:0] ok3_r;
  reg [2:0] ok_r;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ok1_r <= 3'h0;
      ok2_r <= 3'h0;
      ok3_r <= 3'h0;
      ok_r <= 3'h0;
    end else if (clk_en) begin
      ok1_r <= supply_ok;
      ok2_r <= ok1_r;
      ok3_r <= ok2_r;
      ok_r <= (ok2_r & ok3_r) | (ok_r & (ok2_r | ok3_r));
    end
  end

  // --------------------------------------------------------------
  // Configuration, nonvolatile store and write cycle
  // --------------------------------------------------------------
  reg [7:0] nv_store_r;
  reg [7:0] nv_stage_r;
  reg [7:0] cfg_r;
  reg cfg_loaded_r;
  reg [27:0] nvw_cnt_r;
  reg sda_d_r;
  reg write_pend_r;
  wire stop_seen = scl_f && sda_f && !sda_d_r;
  wire bus_wr = avs_write && !avs_waitrequest;
  wire bus_rd = avs_read && !avs_waitrequest;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      nv_store_r <= `PSDT_CFG_DEFAULT;
      nv_stage_r <= `PSDT_CFG_DEFAULT;
      cfg_r <= `PSDT_CFG_DEFAULT;
      cfg_loaded_r <= 1'b0;
      nvw_cnt_r <= 28'h0;
      nv_busy <= 1'b0;
      sda_d_r <= 1'b1;
      write_pend_r <= 1'b0;
    end else if (clk_en) begin
      sda_d_r <= sda_f;
      if (!cfg_loaded_r) begin
        cfg_r <= nv_store_r; // [R9]
        cfg_loaded_r <= 1'b1;
      end
      if (bus_wr && avs_address == `PSDT_ADDR_CFG) begin
        cfg_r <= avs_writedata[7:0];
      end
      if (nv_busy) begin
        if (nvw_cnt_r == 28'h1) begin
          nv_busy <= 1'b0;
          nv_store_r <= nv_stage_r;
        end
        nvw_cnt_r <= nvw_cnt_r - 28'h1;
      end else if (write_pend_r && stop_seen) begin
        nv_busy <= 1'b1; // [R3]
        nvw_cnt_r <= CYC_NVW[27:0];
        write_pend_r <= 1'b0;
      end
      // A new staged write in the cycle a stop is seen keeps its pending flag.
      if (bus_wr && avs_address == `PSDT_ADDR_NVSTAGE && !nv_busy) begin
        nv_stage_r <= avs_writedata[7:0];
        write_pend_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  localparam [1:0] ST_POR = 2'h0;
  localparam [1:0] ST_SEQ = 2'h1;
  localparam [1:0] ST_RST = 2'h2;
  localparam [1:0] ST_RUN = 2'h3;
  reg [1:0] st_r;
  reg [27:0] por_cnt_r;
  reg [27:0] rst_cnt_r;
  reg [27:0] ch_cnt_r [0:2];
  integer i;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= ST_POR;
      por_cnt_r <= 28'h0;
      rst_cnt_r <= 28'h0;
      for (i = 0; i < 3; i = i + 1) ch_cnt_r[i] <= 28'h0;
      supply_good_delayed_output <= 3'h0;
      reset_out_n <= 1'b0;
    end else if (clk_en) begin
      case (st_r)
        ST_POR: begin
          if (cfg_loaded_r) por_cnt_r <= por_cnt_r + 28'h1;
          if (por_cnt_r >= CYC_POR[27:0] - 28'h1) st_r <= ST_SEQ; // [R7]
        end
        ST_SEQ: begin
          for (i = 0; i < 3; i = i + 1) begin
            if (!ok_r[i]) begin
              ch_cnt_r[i] <= 28'h0;
              supply_good_delayed_output[i] <= 1'b0;
            end else if (ch_cnt_r[i] >= sel_cycles(cfg_r[2*i+2 +: 2]) - 28'h1) begin
              supply_good_delayed_output[i] <= 1'b1; // [R2]
            end else begin
              ch_cnt_r[i] <= ch_cnt_r[i] + 28'h1;
            end
          end
          if (&supply_good_delayed_output) begin
            st_r <= ST_RST;
            rst_cnt_r <= 28'h0;
          end
        end
        ST_RST: begin
          if (!(&ok_r)) begin
            st_r <= ST_SEQ;
          end else if (rst_cnt_r >= sel_cycles(cfg_r[1:0]) - 28'h1) begin // [R1] [R6]
            reset_out_n <= 1'b1; // [R8]
            st_r <= ST_RUN;
          end else begin
            rst_cnt_r <= rst_cnt_r + 28'h1;
          end
        end
        default: begin
          if (!(&ok_r)) begin
            reset_out_n <= 1'b0;
            st_r <= ST_SEQ;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer.
  // --------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      scl_filt <= 1'b1;
      sda_filt <= 1'b1;
    end else if (clk_en) begin
      scl_filt <= scl_f;
      sda_filt <= sda_f;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `PSDT_ADDR_CFG: avs_readdata <= {24'h0, cfg_r};
          `PSDT_ADDR_STATUS: avs_readdata <= {24'h0, nv_busy, write_pend_r, st_r,
                                               reset_out_n, supply_good_delayed_output}; // [R4]
          `PSDT_ADDR_NVSTAGE: avs_readdata <= {24'h0, nv_store_r};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end
  wire unused_ok = bus_rd;
endmodule // psdt_top
`default_nettype wire

// file: dv/psdt_checker.sv
// Port assertions for the sequence delay timer.
`timescale 1ns/1ps
`default_nettype none
module psdt_checker #(
  parameter integer CYC_100MS = 20,
  parameter integer CYC_POR = 10,
  parameter integer CYC_NVW = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [2:0] supply_ok,
  input wire logic [2:0] supply_good_delayed_output,
  input wire logic reset_out_n,
  input wire logic sda_in,
  input wire logic sda_filt,
  input wire logic nv_busy
);
  wire [2:0] g = supply_good_delayed_output;
  integer por_r;
  integer nvc_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  always @(posedge sys_clk) begin
    por_r <= !resetn ? 0 : por_r + (por_r < CYC_POR + CYC_100MS);
    nvc_r <= nv_busy ? nvc_r + 1 : 0;
  end
  chk_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("late answer");
  chk_ack_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("long answer");
  chk_good_supply: assert property ((g & ~$past(g) & ~$past(supply_ok, 8)) == 3'h0)
    else $error("good without supply");
  chk_por_wait: assert property (|g |-> por_r >= CYC_POR + CYC_100MS - 2)
    else $error("good too early");
  chk_reset_all: assert property ($rose(reset_out_n) |-> $past(&g, 8))
    else $error("early reset release");
  chk_reset_drop: assert property (!(&supply_ok) |-> ##[0:6] !reset_out_n)
    else $error("reset kept high");
  chk_nv_length: assert property ($fell(nv_busy) |->
    nvc_r >= CYC_NVW - 1 && nvc_r <= 2 * CYC_NVW) else $error("bad write time");
  chk_filt_width: assert property ($changed(sda_filt) |->
    $past(sda_in, 4) == sda_filt && $past(sda_in, 5) == sda_filt) else $error("pulse passed");
endmodule // psdt_checker
bind psdt_top psdt_checker #(.CYC_100MS(CYC_100MS), .CYC_POR(CYC_POR), .CYC_NVW(CYC_NVW))
  chk_u (.*);
`default_nettype wire

// file: dv/psdt_host_model.sv
// Serial host and supply rail model for the sequence delay timer.
`timescale 1ns/1ps
`default_nettype none
module psdt_host_model (
  input wire logic sys_clk,
  input wire logic nv_busy,
  output var logic scl_in = 1'h1,
  output var logic sda_in = 1'h1,
  output var logic [2:0] supply_ok = 3'h7
);
  // Data low for n clocks under a high clock; the release reads as a stop.
  task pulse(input integer n);
    sda_in <= 1'h0;
    repeat (n) @(posedge sys_clk);
    sda_in <= 1'h1;
    @(posedge sys_clk);
  endtask
  // Polls busy rather than waiting out the whole write time.
  task wait_nv(output integer n);
    for (n = 0; n < 99 && nv_busy !== 1'h0; n = n + 1) @(posedge sys_clk);
  endtask
endmodule // psdt_host_model
`default_nettype wire

// file: dv/psdt_bench.sv
// Self-checking bench for the sequence delay timer.
`timescale 1ns/1ps
`default_nettype none
module psdt_bench;
  localparam integer CPOR = 10, CNVW = 8;
  localparam integer D [4] = '{20, 30, 40, 50};
  logic sys_clk = 1'h0, resetn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic avs_waitrequest, reset_out_n, nv_busy, scl_in, sda_in, scl_filt, sda_filt;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [2:0] supply_ok, supply_good_delayed_output;
  logic [1:0] s;
  integer error_cnt = 0, comparisons = 0, k;
  psdt_top #(.CYC_100MS(D[0]), .CYC_500MS(D[1]), .CYC_1S(D[2]), .CYC_5S(D[3]),
    .CYC_POR(CPOR), .CYC_NVW(CNVW)) dut_u (.*, .clk_en(1'h1));
  psdt_host_model pm_u (.*);
  initial forever #20 sys_clk = ~sys_clk;
  task chk(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task bus(input w, input [3:0] a, input [31:0] wd);
    integer n;
    begin
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'h0) @(posedge sys_clk);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge sys_clk);
    end
  endtask
  // Raises the rails when base is 0, then times each good output and the reset release.
  task run(input [7:0] cfg, input integer base);
    integer t, i, tl, tr;
    integer tg [3];
    begin
      if (base == 0) begin
        pm_u.supply_ok <= 3'h0;
        repeat (8) @(posedge sys_clk);
        chk({reset_out_n, supply_good_delayed_output}, 4'h0);
        bus(1'h1, 4'h0, {24'h0, cfg});
        bus(1'h0, 4'h0, 32'h0);
        chk(rd, {24'h0, cfg});
        pm_u.supply_ok <= 3'h7;
      end
      tg = '{0, 0, 0};
      tr = 0;
      for (t = 1; t < 400 && tr == 0; t = t + 1) begin
        @(posedge sys_clk);
        for (i = 0; i < 3; i = i + 1)
          if (supply_good_delayed_output[i] === 1'h1 && tg[i] == 0) tg[i] = t;
        if (reset_out_n === 1'h1) tr = t;
      end
      tl = 0;
      for (i = 0; i < 3; i = i + 1) begin
        chk($unsigned(tg[i] - base - D[cfg[2*i+2 +: 2]]) <= 6, 1);
        if (tg[i] > tl) tl = tg[i];
      end
      chk($unsigned(tr - tl - D[cfg[1:0]]) <= 4, 1);
      bus(1'h0, 4'h4, 32'h0);
      chk(rd, 32'h3f);
    end
  endtask
  task serial_test;
    integer n, z;
    begin
      z = 0;
      pm_u.pulse(1);
      repeat (8) @(posedge sys_clk) z = z | (sda_filt !== 1'h1);
      chk(z, 0);
      chk({scl_filt, sda_filt}, 2'h3);
      bus(1'h1, 4'h8, 32'h5a);
      pm_u.pulse(8);
      for (n = 0; n < 12 && nv_busy !== 1'h1; n = n + 1) @(posedge sys_clk);
      chk(nv_busy, 1'h1);
      bus(1'h1, 4'h8, 32'ha5);
      pm_u.wait_nv(n);
      chk(n <= 2 * CNVW, 1);
      bus(1'h0, 4'h8, 32'h0);
      chk(rd, 32'h5a);
      bus(1'h0, 4'hc, 32'h0);
      chk(rd, 32'h0);
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    run(8'h00, CPOR);
    for (k = 0; k < 4; k = k + 1) begin
      s = k[1:0];
      run({s + 2'h2, s + 2'h1, s, s + 2'h3}, 0);
    end
    serial_test;
    stop_test;
  end
  initial begin
    #(40 * 5000);
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule // psdt_bench
`default_nettype wire
